// file: core/fault_ctrl_pkg.sv
// Constants shared by the optical module fault control design.
package fault_ctrl_pkg;

    // -----------------------------------------------------------------
    // Clock and timing
    // -----------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40_000_000;
    // Longest delay from a light change to the fault pin, in milliseconds.
    localparam int unsigned LIGHT_FLT_MS    = 2;
    // Longest cycle count for that delay, rounded down.
    localparam int unsigned LIGHT_FLT_CYC   = (CLK_HZ / 1000) * LIGHT_FLT_MS;
    // Light detector debounce time in microseconds, a short filter.
    localparam int unsigned LIGHT_DEB_US    = 100;
    localparam int unsigned LIGHT_DEB_CYC   = (CLK_HZ / 1_000_000) * LIGHT_DEB_US;
    // Least inhibit pulse width that the host must give, in nanoseconds.
    localparam int unsigned INHIBIT_MIN_NS  = 100;
    localparam int unsigned INHIBIT_MIN_CYC = (INHIBIT_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // -----------------------------------------------------------------
    // APB register map
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATE  = 8'h04;
    localparam logic [7:0] ADDR_EVENT  = 8'h08;
    localparam logic [7:0] ADDR_CLEAR  = 8'h0c;
    localparam logic [7:0] ADDR_ENABLE = 8'h10;

    // Control field: software inhibit of the laser.
    localparam int unsigned CTRL_SW_INHIBIT = 0;
    localparam logic [0:0]  CTRL_RESET      = 1'h0;

    // State fields.
    localparam int unsigned ST_MOD_FAULT = 0;
    localparam int unsigned ST_LINK_FLT  = 1;
    localparam int unsigned ST_INHIBIT   = 2;
    localparam int unsigned ST_LASER_ON  = 3;

    // Event fields, shared by event, clear and enable registers.
    localparam int unsigned EV_WIDTH      = 4;
    localparam int unsigned EV_MOD_FAULT  = 0;
    localparam int unsigned EV_LINK_LOSS  = 1;
    localparam int unsigned EV_LINK_BACK  = 2;
    localparam int unsigned EV_FAULT_CLR  = 3;
    localparam logic [3:0]  EVENT_RESET   = 4'h0;
    localparam logic [3:0]  ENABLE_RESET  = 4'h0;

    // Light monitor states.
    typedef enum logic [1:0] {
        LIGHT_OK   = 2'b00,
        LIGHT_LOST = 2'b01
    } light_state_t;

endpackage

// file: core/pin_sync_if.sv
// Synchronised pin levels passed from the input stage to the fault core.
`timescale 1ns/1ps
interface pin_sync_if;
    logic inhibit;
    logic inhibit_rise;
    logic light_lost;
    modport src (output inhibit, output inhibit_rise, output light_lost);
    modport dst (input  inhibit, input  inhibit_rise, input  light_lost);
endinterface

// file: core/pin_sync.sv
// Three-stage synchroniser with agreement check for one asynchronous pin.
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // -----------------------------------------------------------------
    // Capture stages
    // -----------------------------------------------------------------
    // The first stage feeds only the second to contain metastability.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_q <= RESET_LEVEL;
            s2_q <= RESET_LEVEL;
            s3_q <= RESET_LEVEL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts once the second and third stages agree.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            level <= RESET_LEVEL;
            rise  <= 1'b0;
        end else begin
            rise <= 1'b0;
            if (s2_q == s3_q) begin
                level <= s3_q;
                rise  <= s3_q & ~level;
            end
        end
    end
endmodule

// file: core/optical_module_fault_control.sv
// Fault latch, link fault timing and laser inhibit for the optical module.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module optical_module_fault_control #(
    parameter int unsigned LIGHT_DEB_CYC = fault_ctrl_pkg::LIGHT_DEB_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Host pins.
    input  wire logic        laser_inhibit_pin,
    output logic             fault_n_out,
    output logic             fault_n_oe,
    // Laser driver and monitor.
    input  wire logic        bias_exhausted,
    input  wire logic        servo_failed,
    input  wire logic        loss_of_light,
    output logic             laser_enable,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);

    // -----------------------------------------------------------------
    // Elaboration checks
    // -----------------------------------------------------------------
    // The debounce must stay well under the link fault bound, or the fault
    // pin could not follow a light change inside the 2 ms limits.
    if (LIGHT_DEB_CYC < 1 || LIGHT_DEB_CYC >= fault_ctrl_pkg::LIGHT_FLT_CYC) begin : g_bad_deb
        $error("Debounce count must be at least one and below the link fault bound.");
    end

    // The debounce counter is sized for the whole link fault bound.
    localparam int unsigned CW = $clog2(fault_ctrl_pkg::LIGHT_FLT_CYC + 1);

    // -----------------------------------------------------------------
    // Pin synchronisation
    // -----------------------------------------------------------------
    // Synchronised host and light levels travel to the fault logic together.
    pin_sync_if sync_bus ();

    logic bias_s;
    logic servo_s;

    pin_sync #(
        .RESET_LEVEL (1'b1)
    ) u_inhibit_sync (
        .clock (clock),
        .rst_n (rst_n),
        .pin   (laser_inhibit_pin),
        .level (sync_bus.inhibit),
        .rise  (sync_bus.inhibit_rise)
    );

    pin_sync #(
        .RESET_LEVEL (1'b0)
    ) u_light_sync (
        .clock (clock),
        .rst_n (rst_n),
        .pin   (loss_of_light),
        .level (sync_bus.light_lost),
        .rise  ()
    );

    // end of life synchroniser
    // The laser detectors run outside the clock domain, like the host pins.
    pin_sync #(
        .RESET_LEVEL (1'b0)
    ) u_bias_sync (
        .clock (clock),
        .rst_n (rst_n),
        .pin   (bias_exhausted),
        .level (bias_s),
        .rise  ()
    );

    pin_sync #(
        .RESET_LEVEL (1'b0)
    ) u_servo_sync (
        .clock (clock),
        .rst_n (rst_n),
        .pin   (servo_failed),
        .level (servo_s),
        .rise  ()
    );

    // -----------------------------------------------------------------
    // Module fault latch
    // -----------------------------------------------------------------
    logic mod_fault_q;
    logic mod_detect;

    assign mod_detect = bias_s | servo_s;

    // Detection is masked while inhibit is high, since the laser is off
    // and its monitors read failure; this keeps the latch clear then.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mod_fault_q <= 1'b0;
        end else if (sync_bus.inhibit_rise) begin
            mod_fault_q <= 1'b0;
        end else if (sync_bus.inhibit) begin
            mod_fault_q <= 1'b0;
        end else if (mod_detect) begin
            mod_fault_q <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Link fault debounce
    // -----------------------------------------------------------------
    fault_ctrl_pkg::light_state_t light_q;
    logic [CW-1:0]                deb_q;
    logic                         link_fault;

    // The detector must hold a new level for the debounce time before the
    // link fault follows it, well inside the 2 ms bound in both directions.
    // A glitch shorter than the debounce restarts the count from zero.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            light_q <= fault_ctrl_pkg::LIGHT_OK;
            deb_q   <= '0;
        end else begin
            case (light_q)
                fault_ctrl_pkg::LIGHT_OK: begin
                    if (!sync_bus.light_lost) begin
                        deb_q <= '0;
                    end else if (deb_q == CW'(LIGHT_DEB_CYC - 1)) begin
                        light_q <= fault_ctrl_pkg::LIGHT_LOST;
                        deb_q   <= '0;
                    end else begin
                        deb_q <= deb_q + CW'(1);
                    end
                end
                fault_ctrl_pkg::LIGHT_LOST: begin
                    if (sync_bus.light_lost) begin
                        deb_q <= '0;
                    end else if (deb_q == CW'(LIGHT_DEB_CYC - 1)) begin
                        light_q <= fault_ctrl_pkg::LIGHT_OK;
                        deb_q   <= '0;
                    end else begin
                        deb_q <= deb_q + CW'(1);
                    end
                end
                default: begin
                    light_q <= fault_ctrl_pkg::LIGHT_OK;
                    deb_q   <= '0;
                end
            endcase
        end
    end

    assign link_fault = (light_q == fault_ctrl_pkg::LIGHT_LOST);

    // -----------------------------------------------------------------
    // Pin outputs
    // -----------------------------------------------------------------
    logic sw_inhibit_q;
    logic any_fault;

    assign any_fault = mod_fault_q | link_fault;

    // The pin is pulled low only while a fault is present.
    // Out of reset the data bit stays low and only the enable moves, so a released pin
    // rises by the host's pull-up and is never driven high.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fault_n_out <= 1'b1;
            fault_n_oe  <= 1'b0;
        end else begin
            fault_n_out <= 1'b0;
            fault_n_oe  <= any_fault;
        end
    end

    // Laser runs only with no inhibit and no latched module fault.
    // A cause still present keeps the laser dark before the latch catches it.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            laser_enable <= 1'b0;
        end else begin
            laser_enable <= ~sync_bus.inhibit & ~sw_inhibit_q & ~mod_fault_q & ~mod_detect;
        end
    end

    // -----------------------------------------------------------------
    // Event flags and interrupt
    // -----------------------------------------------------------------
    logic [fault_ctrl_pkg::EV_WIDTH-1:0] event_q;
    logic [fault_ctrl_pkg::EV_WIDTH-1:0] enable_q;
    logic [fault_ctrl_pkg::EV_WIDTH-1:0] ev_set;
    logic [fault_ctrl_pkg::EV_WIDTH-1:0] ev_clr;
    logic                                mod_fault_d1_q;
    logic                                link_d1_q;
    logic                                wr_go;

    assign wr_go = psel & penable & pwrite;

    // Delayed copies for edge detection of the fault sources.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mod_fault_d1_q <= 1'b0;
            link_d1_q      <= 1'b0;
        end else begin
            mod_fault_d1_q <= mod_fault_q;
            link_d1_q      <= link_fault;
        end
    end

    // Event sources are the edges of both faults; the software clear mask
    // acts only in the access cycle of a write to the clear register.
    always_comb begin
        ev_set = '0;
        ev_set[fault_ctrl_pkg::EV_MOD_FAULT] = mod_fault_q & ~mod_fault_d1_q;
        ev_set[fault_ctrl_pkg::EV_LINK_LOSS] = link_fault & ~link_d1_q;
        ev_set[fault_ctrl_pkg::EV_LINK_BACK] = ~link_fault & link_d1_q;
        ev_set[fault_ctrl_pkg::EV_FAULT_CLR] = ~mod_fault_q & mod_fault_d1_q;
        ev_clr = '0;
        if (wr_go && paddr == fault_ctrl_pkg::ADDR_CLEAR) begin
            ev_clr = pwdata[fault_ctrl_pkg::EV_WIDTH-1:0];
        end
    end

    // Sticky flags: a set in the same cycle as a clear wins.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            event_q <= fault_ctrl_pkg::EVENT_RESET;
        end else begin
            event_q <= (event_q & ~ev_clr) | ev_set;
        end
    end

    // Level interrupt from enabled flags.
    // It is built from the next flag value, so irq moves with the flags
    // instead of one cycle behind them.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((event_q & ~ev_clr) | ev_set) & enable_q);
        end
    end

    // -----------------------------------------------------------------
    // APB register access
    // -----------------------------------------------------------------
    // Writable control and enable registers.
    // Writes land in the access cycle, where pready is always high.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sw_inhibit_q <= fault_ctrl_pkg::CTRL_RESET;
            enable_q     <= fault_ctrl_pkg::ENABLE_RESET;
        end else if (wr_go) begin
            if (paddr == fault_ctrl_pkg::ADDR_CTRL) begin
                sw_inhibit_q <= pwdata[fault_ctrl_pkg::CTRL_SW_INHIBIT];
            end
            if (paddr == fault_ctrl_pkg::ADDR_ENABLE) begin
                enable_q <= pwdata[fault_ctrl_pkg::EV_WIDTH-1:0];
            end
        end
    end

    // Zero wait states; read data and error registered in the setup cycle.
    // An unmapped address answers with an error and changes nothing.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    fault_ctrl_pkg::ADDR_CTRL: begin
                        prdata[fault_ctrl_pkg::CTRL_SW_INHIBIT] <= sw_inhibit_q;
                    end
                    fault_ctrl_pkg::ADDR_STATE: begin
                        prdata[fault_ctrl_pkg::ST_MOD_FAULT] <= mod_fault_q;
                        prdata[fault_ctrl_pkg::ST_LINK_FLT]  <= link_fault;
                        prdata[fault_ctrl_pkg::ST_INHIBIT]   <= sync_bus.inhibit;
                        prdata[fault_ctrl_pkg::ST_LASER_ON]  <= laser_enable;
                    end
                    fault_ctrl_pkg::ADDR_EVENT: begin
                        prdata[fault_ctrl_pkg::EV_WIDTH-1:0] <= event_q;
                    end
                    fault_ctrl_pkg::ADDR_CLEAR: begin
                        prdata <= 32'h0000_0000;
                    end
                    fault_ctrl_pkg::ADDR_ENABLE: begin
                        prdata[fault_ctrl_pkg::EV_WIDTH-1:0] <= enable_q;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

// file: test/fault_ctrl_assertions.sv
// Concurrent checks on the fault pin, the inhibit input and the laser enable.
`timescale 1ns/1ps
module fault_ctrl_assertions #(
    parameter int unsigned LIGHT_DEB_CYC = 4000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic laser_inhibit_pin,
    input wire logic fault_n_out,
    input wire logic fault_n_oe,
    input wire logic bias_exhausted,
    input wire logic servo_failed,
    input wire logic loss_of_light,
    input wire logic laser_enable
);
    // Cycles by which a light or inhibit change must have reached the pin.
    localparam logic [15:0] SETTLE = 16'(LIGHT_DEB_CYC + 12);

    logic [15:0] lost_cnt_q;
    logic [15:0] inh_cnt_q;
    logic [15:0] quiet_cnt_q;
    logic        cleared_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // -----------------------------------------------------------------
    // Helper counters
    // -----------------------------------------------------------------
    // Counts cycles of continuous light loss, saturating.
    always_ff @(posedge clock) begin
        lost_cnt_q <= (rst_n && loss_of_light) ? lost_cnt_q + {15'h0000, ~&lost_cnt_q} : 16'h0000;
    end

    // Counts cycles of inhibit held high while light is present.
    always_ff @(posedge clock) begin
        inh_cnt_q <= (rst_n && laser_inhibit_pin && !loss_of_light) ? inh_cnt_q + {15'h0000, ~&inh_cnt_q} : 16'h0000;
    end

    // Low from a fault detect until the host has raised inhibit again.
    always_ff @(posedge clock) begin
        if (!rst_n || laser_inhibit_pin) begin
            cleared_q <= 1'b1;
        end else if (servo_failed || bias_exhausted) begin
            cleared_q <= 1'b0;
        end
    end

    // Counts cycles with no fault cause present and no latch outstanding.
    always_ff @(posedge clock) begin
        quiet_cnt_q <= (rst_n && cleared_q && !loss_of_light && !servo_failed && !bias_exhausted)
            ? quiet_cnt_q + {15'h0000, ~&quiet_cnt_q} : 16'h0000;
    end

    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    sequence s_servo_held;
        (servo_failed && !laser_inhibit_pin)[*8];
    endsequence

    sequence s_bias_held;
        (bias_exhausted && !laser_inhibit_pin)[*8];
    endsequence

    a_inhibit_laser_off: assert property (laser_inhibit_pin[*8] |-> !laser_enable)
        else $error("laser enabled while inhibit held");
    a_drain_low_only: assert property ($past(rst_n) |-> fault_n_out == 1'b0)
        else $error("fault pin data not low");
    a_end_life_fault: assert property (s_bias_held |-> ##[0:4] fault_n_oe)
        else $error("end of life did not assert fault");
    a_servo_fault_set: assert property (s_servo_held |-> ##[0:4] fault_n_oe)
        else $error("servo failure did not assert fault");
    a_fault_latch_hold: assert property (
        s_servo_held ##1 (!servo_failed && !laser_inhibit_pin)[*8] |-> fault_n_oe)
        else $error("module fault not held");
    a_inhibit_clears: assert property (inh_cnt_q >= SETTLE |-> !fault_n_oe)
        else $error("fault asserted during inhibit hold");
    a_light_loss_fault: assert property (lost_cnt_q >= SETTLE |-> fault_n_oe)
        else $error("light loss did not assert fault");
    a_link_release: assert property (quiet_cnt_q >= SETTLE |-> !fault_n_oe)
        else $error("fault held with no cause");
endmodule

bind optical_module_fault_control fault_ctrl_assertions #(.LIGHT_DEB_CYC(LIGHT_DEB_CYC)) checks (
    .clock             (clock),
    .rst_n             (rst_n),
    .laser_inhibit_pin (laser_inhibit_pin),
    .fault_n_out       (fault_n_out),
    .fault_n_oe        (fault_n_oe),
    .bias_exhausted    (bias_exhausted),
    .servo_failed      (servo_failed),
    .loss_of_light     (loss_of_light),
    .laser_enable      (laser_enable)
);

// file: test/host_model.sv
// Host adapter model: pull-up on the fault wire and driver of the inhibit pin.
`timescale 1ns/1ps
module host_model (
    input  wire logic       clock,
    input  wire logic       fault_n_out,
    input  wire logic       fault_n_oe,
    input  wire logic       clear_req,
    input  wire logic [7:0] hold_cyc,
    output logic            laser_inhibit_pin,
    output logic            fault_wire
);
    logic [7:0] left_q;
    logic       tried_q;

    // Shortest inhibit pulse that the host gives, in whole clock cycles.
    localparam logic [7:0] MIN_HOLD = 8'(fault_ctrl_pkg::INHIBIT_MIN_CYC);

    assign fault_wire = fault_n_oe ? fault_n_out : 1'b1;

    // Idle host: inhibit low, no pulse pending.
    initial begin
        laser_inhibit_pin = 1'b0;
        left_q = 8'h00;
        tried_q = 1'b0;
    end

    // one inhibit pulse of at least four cycles per fault.
    always @(posedge clock) begin
        if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
            laser_inhibit_pin <= (left_q != 8'h01);
        end else if (clear_req && !tried_q) begin
            left_q <= (hold_cyc < MIN_HOLD) ? MIN_HOLD : hold_cyc;
            laser_inhibit_pin <= 1'b1;
            tried_q <= !fault_wire;
        end else if (fault_wire) begin
            tried_q <= 1'b0;
        end
    end
endmodule

// file: test/tb.sv
// Self-checking testbench for the optical module fault control block.
`timescale 1ns/1ps
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch at %0t got %0h expected %0h", $time, (g), (e)); end end
module tb;
    localparam int unsigned DEB = 16;

    logic        clock;
    logic        rst_n;
    logic        laser_inhibit_pin;
    logic        fault_n_out;
    logic        fault_n_oe;
    logic        fault_wire;
    logic        bias_exhausted;
    logic        servo_failed;
    logic        loss_of_light;
    logic        laser_enable;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        clear_req;
    logic [7:0]  hold_cyc;
    logic [31:0] rdata;
    logic        rerr;
    int          fail_count;
    int          cmp_count;

    optical_module_fault_control #(.LIGHT_DEB_CYC(DEB)) dut (
        .clock             (clock),
        .rst_n             (rst_n),
        .laser_inhibit_pin (laser_inhibit_pin),
        .fault_n_out       (fault_n_out),
        .fault_n_oe        (fault_n_oe),
        .bias_exhausted    (bias_exhausted),
        .servo_failed      (servo_failed),
        .loss_of_light     (loss_of_light),
        .laser_enable      (laser_enable),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .irq               (irq)
    );

    host_model host (
        .clock             (clock),
        .fault_n_out       (fault_n_out),
        .fault_n_oe        (fault_n_oe),
        .clear_req         (clear_req),
        .hold_cyc          (hold_cyc),
        .laser_inhibit_pin (laser_inhibit_pin),
        .fault_wire        (fault_wire)
    );

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One APB transfer; read data and error flag land in rdata and rerr.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Asks the host model for one inhibit pulse of n cycles.
    task automatic clear_pulse(input logic [7:0] n);
        @(posedge clock);
        clear_req <= 1'b1;
        hold_cyc <= n;
        @(posedge clock);
        clear_req <= 1'b0;
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset_state();
        logic [7:0] zero_regs [4];
        zero_regs = '{fault_ctrl_pkg::ADDR_CTRL, fault_ctrl_pkg::ADDR_EVENT,
                      fault_ctrl_pkg::ADDR_CLEAR, fault_ctrl_pkg::ADDR_ENABLE};
        apb(1'b0, fault_ctrl_pkg::ADDR_STATE, 32'h0000_0000);
        `CHECK(rdata, 32'h0000_0008)
        `CHECK(fault_wire, 1'b1)
        foreach (zero_regs[i]) begin
            apb(1'b0, zero_regs[i], 32'h0000_0000);
            `CHECK({rerr, rdata}, 33'h0_0000_0000)
        end
        apb(1'b1, fault_ctrl_pkg::ADDR_CTRL, 32'h0000_0001);
        apb(1'b0, fault_ctrl_pkg::ADDR_STATE, 32'h0000_0000);
        `CHECK(rdata, 32'h0000_0000)
        apb(1'b1, fault_ctrl_pkg::ADDR_CTRL, 32'h0000_0000);
        tick(2);
        `CHECK(laser_enable, 1'b1)
        apb(1'b1, 8'h20, 32'hffff_ffff);
        `CHECK(rerr, 1'b1)
        $display("test reset_state done");
    endtask

    task automatic t_servo_fault();
        apb(1'b1, fault_ctrl_pkg::ADDR_ENABLE, 32'h0000_0001);
        servo_failed <= 1'b1;
        tick(12);
        servo_failed <= 1'b0;
        tick(20);
        `CHECK(fault_wire, 1'b0)
        `CHECK(laser_enable, 1'b0)
        `CHECK(irq, 1'b1)
        apb(1'b1, fault_ctrl_pkg::ADDR_ENABLE, 32'h0000_0000);
        tick(2);
        `CHECK(irq, 1'b0)
        apb(1'b1, fault_ctrl_pkg::ADDR_ENABLE, 32'h0000_0001);
        apb(1'b1, fault_ctrl_pkg::ADDR_CLEAR, 32'h0000_000f);
        tick(2);
        `CHECK(irq, 1'b0)
        clear_pulse(8'h06);
        tick(16);
        `CHECK(fault_wire, 1'b1)
        `CHECK(laser_enable, 1'b1)
        $display("test servo_fault done");
    endtask

    task automatic t_bias_inhibit();
        bias_exhausted <= 1'b1;
        tick(16);
        `CHECK(fault_wire, 1'b0)
        clear_pulse(8'h3c);
        tick(40);
        `CHECK(fault_wire, 1'b1)
        `CHECK(laser_enable, 1'b0)
        apb(1'b0, fault_ctrl_pkg::ADDR_STATE, 32'h0000_0000);
        `CHECK(rdata, 32'h0000_0004)
        tick(40);
        `CHECK(fault_wire, 1'b0)
        bias_exhausted <= 1'b0;
        clear_pulse(8'h06);
        tick(20);
        `CHECK(fault_wire, 1'b1)
        $display("test bias_inhibit done");
    endtask

    task automatic t_link_fault();
        apb(1'b1, fault_ctrl_pkg::ADDR_CLEAR, 32'h0000_000f);
        loss_of_light <= 1'b1;
        tick(DEB + 20);
        `CHECK(fault_wire, 1'b0)
        apb(1'b0, fault_ctrl_pkg::ADDR_STATE, 32'h0000_0000);
        `CHECK(rdata[1:0], 2'b10)
        clear_pulse(8'h06);
        tick(20);
        `CHECK(fault_wire, 1'b0)
        loss_of_light <= 1'b0;
        tick(DEB + 20);
        `CHECK(fault_wire, 1'b1)
        apb(1'b0, fault_ctrl_pkg::ADDR_EVENT, 32'h0000_0000);
        `CHECK(rdata & 32'h0000_0006, 32'h0000_0006)
        $display("test link_fault done");
    endtask

    // -----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // -----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Drives every input to idle, holds reset, then runs the scenarios.
    initial begin
        rst_n = 1'b0;
        {bias_exhausted, servo_failed, loss_of_light} = 3'b000;
        {psel, penable, pwrite, clear_req} = 4'b0000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        hold_cyc = 8'h06;
        fail_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        tick(8);
        t_reset_state();
        t_servo_fault();
        t_bias_inhibit();
        t_link_fault();
        final_report();
    end

    // Cuts a hang short well after the scenarios should have ended.
    initial begin
        #125000;
        fail_count++;
        final_report();
    end
endmodule
